// >>> rtcc_defines.vh
// Constants for the RTC control, charger and EEPROM page slave
// How it works
// - Oscillator halt bit set stops oscillator only after changing over to battery.
// - On main supply the oscillator always runs, whatever the halt bit holds.
// - Control bits six to two read zero and ignore writes.
// - Watchdog enable one lets the counter count; zero makes it plain storage.
// - Routing bit clear: expiry leaves reset undriven and only sets alarm flag.
// - Power-up clears halt, watchdog enable and routing bits.
// - Charger enabled only when upper nibble of charger register holds 1010.
// - Power-up clears whole charger register, charger disabled.
// - Diode field 01 no diode, 10 one diode, 00 and 11 disable.
// - Resistor field 01 250 ohm, 10 2k, 11 4k, 00 disables.
// - Storage is two 256-byte blocks of 32 eight-byte pages, one page per write.
// - Pages start at word addresses that are multiples of eight.
// - Page write past page end wraps to start of same page.
// - Device is bus slave only, never drives clock, works to 400kHz.
// - Data falling while clock high is a start condition.
// - Data rising while clock high is a stop condition.
// - Data changes only while clock low; one bit per clock pulse.
// - Address byte upper nibble 1101, then three block bits, then read bit.
// - During programming cycle, no acknowledge for nonvolatile block access.
`ifndef RTCC_DEFINES_VH
`define RTCC_DEFINES_VH
`define RTCC_CTRL_CODE 4'hd
`define RTCC_ADDR_CHG 8'h0_a
`define RTCC_ADDR_CTL 8'h0_c
`define RTCC_ADDR_FLAG 8'h0_b
`define RTCC_UNLOCK 4'h_a
`define RTCC_CTL_HALT 7
`define RTCC_CTL_WD_EN 1
`define RTCC_CTL_WDR 0
`define RTCC_CTL_MASK 8'h8_3
`define RTCC_CHG_RESET 8'h0_0
`define RTCC_CTL_RESET 8'h0_0
`define RTCC_PAGE_BYTES 8
`define RTCC_RST_PULSE_MS 250
`define RTCC_PROG_MS 10
`define RTCC_CLK_KHZ 25000
`endif

// >>> rtcc_i2c_mst.sv
// Bus master model driving the serial clock and pulling data low
`timescale 1ns/1ps
module rtcc_i2c_mst (
   input wire mclk, // bench clock
   input wire sda, // resolved data line
   output reg scl = 1'b1, // bus clock
   output reg sda_low = 1'b0 // pulls data low
);
   reg r;
   integer k;
   task q;
      repeat (2) @(posedge mclk);
   endtask
   // Data released with the clock low first, so a late ack release is no stop
   task start;
      sda_low <= 1'b0;
      q;
      scl <= 1'b1;
      q;
      sda_low <= 1'b1;
      q;
      scl <= 1'b0;
      q;
   endtask
   task stop;
      sda_low <= 1'b1;
      q;
      scl <= 1'b1;
      q;
      sda_low <= 1'b0;
      q;
   endtask
   task bit_x(input b, output o);
      sda_low <= !b;
      q;
      scl <= 1'b1;
      q;
      o = sda;
      q;
      scl <= 1'b0;
      q;
   endtask
   task wbyte(input [7:0] v, output a);
      for (k = 7; k >= 0; k--) bit_x(v[k], r);
      bit_x(1'b1, r);
      a = !r;
   endtask
   task rbyte(input last, output [7:0] v);
      for (k = 7; k >= 0; k--) begin
         bit_x(1'b1, r);
         v[k] = r;
      end
      bit_x(last, r);
   endtask
endmodule // rtcc_i2c_mst

// >>> rtcc_slave.v
// I2C slave with control, charger registers and paged EEPROM blocks
`timescale 1ns/1ps
`include "rtcc_defines.vh"
module rtcc_slave #(
   parameter RST_CYCLES = `RTCC_RST_PULSE_MS * `RTCC_CLK_KHZ,
   parameter PROG_CYCLES = `RTCC_PROG_MS * `RTCC_CLK_KHZ
) (
   input wire mclk, // system clock
   input wire rst_n, // async reset, active low
   input wire clk_en, // freezes all state while low
   input wire scl_in, // bus clock pin level
   input wire sda_in, // bus data pin level
   input wire on_battery, // supply monitor: running from backup
   input wire wd_expire, // pulse: watchdog count reached zero
   output reg sda_oe, // drive data low while high
   output reg sda_out, // data drive level, always zero
   output reg reset_out_oe, // drive reset output low while high
   output reg reset_out, // reset drive level, always zero
   output reg osc_run, // oscillator running
   output reg watchdog_run, // watchdog counter allowed to count
   output reg watchdog_alarm_flag, // sticky alarm flag
   output reg charger_on, // trickle charger enabled
   output reg charger_diode, // one series diode inserted
   output reg [1:0] series_resistor_field, // resistor selected when enabled
   output reg prog_busy // nonvolatile programming cycle running
);
// ==========================================
// Input synchronisers
// Bus pins idle high, so their stages reset high and no false start follows reset
reg [1:0] scl_s;
reg [1:0] sda_s;
// The supply level is slow but still crosses domains, so it gets two stages too
reg [1:0] bat_s;
reg scl_d;
reg sda_d;
always @(posedge mclk or negedge rst_n) begin
   if (!rst_n) begin
      scl_s <= 2'b11;
      sda_s <= 2'b11;
      bat_s <= 2'b00;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
   end else if (clk_en) begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      bat_s <= {bat_s[0], on_battery};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
   end
end
wire scl = scl_s[1];
wire sda = sda_s[1];
wire scl_rise = scl & ~scl_d;
wire scl_fall = ~scl & scl_d;
wire start_cond = scl & scl_d & sda_d & ~sda;
wire stop_cond = scl & scl_d & ~sda_d & sda;
// ==========================================
// Registers and memory
reg [7:0] chg_reg;
reg [7:0] ctl_reg;
reg [7:0] ptr;
reg [7:0] mem [0:511];
reg [7:0] pbuf [0:7];
reg [7:0] pmask;
reg [8:0] pbase;
reg [2:0] blk;
reg rd_mode;
function [7:0] rtcc_rd;
   input [2:0] b;
   input [7:0] a;
   begin
      if (b == 3'd0) begin
         case (a)
            `RTCC_ADDR_CHG: rtcc_rd = chg_reg;
            `RTCC_ADDR_CTL: rtcc_rd = ctl_reg & `RTCC_CTL_MASK;
            `RTCC_ADDR_FLAG: rtcc_rd = {1'b0, watchdog_alarm_flag, 6'h00};
            default: rtcc_rd = 8'h0_0;
         endcase
      end else begin
         rtcc_rd = mem[{b[1] , a}];
      end
   end
endfunction
// ==========================================
// Address byte decode
function rtcc_addr_ok;
   input [7:0] a;
   input busy;
   begin
      // EEPROM blocks are refused while a page is programming, block 0 never
      rtcc_addr_ok = (a[7:4] == `RTCC_CTRL_CODE) && !a[3] &&
         (a[2:1] != 2'b11) &&
         !(busy && (a[2:1] != 2'b00));
   end
endfunction
// ==========================================
// Bus state machine
localparam ST_IDLE = 3'd0;
localparam ST_ADDR = 3'd1;
localparam ST_WORD = 3'd2;
localparam ST_WDATA = 3'd3;
localparam ST_RDATA = 3'd4;
localparam ST_ACK = 3'd5;
localparam ST_MACK = 3'd6;
reg [2:0] st;
reg [2:0] ret_st;
reg [3:0] bitn;
reg [7:0] sh;
reg ack_pend;
reg wr_commit;
reg [31:0] prog_cnt;
reg [31:0] rst_cnt;
// Byte for the current pointer, loaded on the ack clock fall
wire [7:0] rd_byte = rtcc_rd(blk, ptr);
// An expiry only counts while the watchdog is enabled
wire wd_hit = wd_expire & ctl_reg[`RTCC_CTL_WD_EN];
integer i;
always @(posedge mclk or negedge rst_n) begin
   if (!rst_n) begin
      st <= ST_IDLE;
      ret_st <= ST_IDLE;
      bitn <= 4'd0;
      sh <= 8'h0_0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      ptr <= 8'h0_0;
      blk <= 3'd0;
      rd_mode <= 1'b0;
      ack_pend <= 1'b0;
      wr_commit <= 1'b0;
      pmask <= 8'h0_0;
      pbase <= 9'd0;
      chg_reg <= `RTCC_CHG_RESET;
      ctl_reg <= `RTCC_CTL_RESET;
      watchdog_alarm_flag <= 1'b0;
      prog_busy <= 1'b0;
      prog_cnt <= 32'd0;
      for (i = 0; i < 8; i = i + 1) begin
         pbuf[i] <= 8'h0_0;
      end
   end else if (clk_en) begin
      wr_commit <= 1'b0;
      // Set wins over a clear in the same cycle
      if (wd_hit) begin
         watchdog_alarm_flag <= 1'b1;
      end
      // Busy time counts down from the stop that committed the page
      if (prog_busy) begin
         if (prog_cnt == 32'd0) begin
            prog_busy <= 1'b0;
         end else begin
            prog_cnt <= prog_cnt - 32'd1;
         end
      end
      // A start, repeated or not, drops a page that no stop has closed
      if (start_cond) begin
         st <= ST_ADDR;
         bitn <= 4'd0;
         sda_oe <= 1'b0;
         pmask <= 8'h0_0;
      end else if (stop_cond) begin
         st <= ST_IDLE;
         sda_oe <= 1'b0;
         // Programming starts only at stop, from the page buffer
         if (pmask != 8'h0_0) begin
            for (i = 0; i < 8; i = i + 1) begin
               if (pmask[i]) begin
                  mem[pbase + i[8:0]] <= pbuf[i];
               end
            end
            prog_busy <= 1'b1;
            prog_cnt <= PROG_CYCLES - 1;
            pmask <= 8'h0_0;
         end
      end else begin
         case (st)
            ST_IDLE: begin
               sda_oe <= 1'b0;
            end
            ST_ADDR, ST_WORD, ST_WDATA: begin
               if (scl_rise) begin
                  sh <= {sh[6:0], sda};
                  bitn <= bitn + 4'd1;
               end
               if (scl_fall && bitn == 4'd8) begin
                  bitn <= 4'd0;
                  ack_pend <= 1'b1;
                  // Refused addresses leave the data line alone until the next start
                  if (st == ST_ADDR) begin
                     if (rtcc_addr_ok(sh, prog_busy)) begin
                        blk <= sh[3:1];
                        rd_mode <= sh[0];
                        sda_oe <= 1'b1;
                        st <= ST_ACK;
                        ret_st <= sh[0] ? ST_RDATA : ST_WORD;
                     end else begin
                        st <= ST_IDLE;
                     end
                  end else if (st == ST_WORD) begin
                     ptr <= sh;
                     pbase <= {blk[1], sh[7:3], 3'd0};
                     sda_oe <= 1'b1;
                     st <= ST_ACK;
                     ret_st <= ST_WDATA;
                  end else begin
                     if (blk == 3'd0) begin
                        if (ptr == `RTCC_ADDR_CHG) begin
                           chg_reg <= sh;
                        end
                        if (ptr == `RTCC_ADDR_CTL) begin
                           ctl_reg <= sh & `RTCC_CTL_MASK;
                        end
                        // Software may only clear the alarm; a fresh expiry wins
                        if (ptr == `RTCC_ADDR_FLAG && !sh[6] && !wd_hit) begin
                           watchdog_alarm_flag <= 1'b0;
                        end
                        ptr <= ptr + 8'd1;
                     end else begin
                        // Only the low pointer bits move, so a long write stays in its page
                        pbuf[ptr[2:0]] <= sh;
                        pmask[ptr[2:0]] <= 1'b1;
                        ptr <= {ptr[7:3], ptr[2:0] + 3'd1};
                     end
                     sda_oe <= 1'b1;
                     st <= ST_ACK;
                     ret_st <= ST_WDATA;
                  end
               end
            end
            // The ack is held through the ninth clock; on its fall it is released, or a read drives out bit seven of the next byte
            ST_ACK: begin
               if (scl_fall) begin
                  if (ret_st == ST_RDATA) begin
                     sh <= rd_byte;
                     sda_oe <= ~rd_byte[7];
                     // Reads step the full pointer; the page wrap is for writes only
                     ptr <= ptr + 8'd1;
                     bitn <= 4'd1;
                  end else begin
                     sda_oe <= 1'b0;
                  end
                  st <= ret_st;
               end
            end
            // Bit seven went out at the ack fall; the rest follow each clock fall
            ST_RDATA: begin
               if (scl_fall) begin
                  if (bitn == 4'd8) begin
                     sda_oe <= 1'b0;
                     st <= ST_MACK;
                  end else begin
                     sda_oe <= ~sh[7 - bitn[2:0]];
                     bitn <= bitn + 4'd1;
                  end
               end
            end
            // A high level in the master's ack slot ends the read
            ST_MACK: begin
               if (scl_rise) begin
                  st <= sda ? ST_IDLE : ST_ACK;
                  ret_st <= ST_RDATA;
               end
            end
            default: st <= ST_IDLE;
         endcase
      end
   end
end
// ==========================================
// Control outputs
// Charger only when unlock, diode and resistor fields are all legal
wire chg_en = (chg_reg[7:4] == `RTCC_UNLOCK) & (chg_reg[3:2] == 2'b01 | chg_reg[3:2] == 2'b10) &
   (chg_reg[1:0] != 2'b00);
always @(posedge mclk or negedge rst_n) begin
   if (!rst_n) begin
      osc_run <= 1'b1;
      watchdog_run <= 1'b0;
      charger_on <= 1'b0;
      charger_diode <= 1'b0;
      series_resistor_field <= 2'b00;
      reset_out_oe <= 1'b0;
      reset_out <= 1'b0;
      rst_cnt <= 32'd0;
   end else if (clk_en) begin
      // Halt applies on battery only; mains always keeps the oscillator running
      osc_run <= ~(bat_s[1] & ctl_reg[`RTCC_CTL_HALT]);
      watchdog_run <= ctl_reg[`RTCC_CTL_WD_EN];
      charger_on <= chg_en;
      charger_diode <= chg_en & (chg_reg[3:2] == 2'b10);
      series_resistor_field <= chg_en ? chg_reg[1:0] : 2'b00;
      // An expiry during a pulse restarts it rather than being lost
      if (wd_hit && ctl_reg[`RTCC_CTL_WDR]) begin
         reset_out_oe <= 1'b1;
         rst_cnt <= RST_CYCLES - 1;
      end else if (rst_cnt != 32'd0) begin
         rst_cnt <= rst_cnt - 32'd1;
      end else begin
         reset_out_oe <= 1'b0;
      end
   end
end
endmodule // rtcc_slave

// >>> rtcc_slave_properties.sv
// Assertions on the ports of the control, charger and page slave
`timescale 1ns/1ps
module rtcc_slave_chk #(
   parameter RST_CYCLES = 20
) (
   input wire mclk, // clock
   input wire rst_n, // reset
   input wire scl_in, // bus clock
   input wire sda_in, // bus data
   input wire on_battery, // backup supply
   input wire wd_expire, // expiry pulse
   input wire sda_oe, // data pull
   input wire reset_out_oe, // reset pull
   input wire osc_run, // oscillator
   input wire watchdog_run, // watchdog
   input wire watchdog_alarm_flag, // alarm
   input wire charger_on, // charger
   input wire [1:0] series_resistor_field, // resistor
   input wire prog_busy // programming
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // Reset pulse length
   int rcnt;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         rcnt <= 0;
      else
         rcnt <= reset_out_oe ? rcnt + 1 : 0;
   end
   // ==========================================
   // Properties
   property p_osc_mains; (!on_battery) [*5] |-> osc_run; endproperty
   a_osc_mains: assert property (p_osc_mains) else $error("osc off on mains");
   property p_osc_stop; $fell(osc_run) |-> on_battery; endproperty
   a_osc_stop: assert property (p_osc_stop) else $error("osc stop off battery");
   property p_rst_armed; $rose(reset_out_oe) |-> watchdog_run; endproperty
   a_rst_armed: assert property (p_rst_armed) else $error("reset unarmed");
   // One cycle of slack either way for the synchroniser
   property p_rst_len;
      $fell(reset_out_oe) |-> rcnt >= RST_CYCLES - 1 && rcnt <= RST_CYCLES + 1;
   endproperty
   a_rst_len: assert property (p_rst_len) else $error("reset pulse length");
   property p_flag; wd_expire && watchdog_run |-> ##[1:2] watchdog_alarm_flag; endproperty
   a_flag: assert property (p_flag) else $error("alarm not set");
   property p_chg_res; charger_on |-> series_resistor_field != 2'h0; endproperty
   a_chg_res: assert property (p_chg_res) else $error("charger without resistor");
   property p_sda_move; $changed(sda_oe) |-> !scl_in; endproperty
   a_sda_move: assert property (p_sda_move) else $error("data moved, clock high");
   property p_prog_stop; $rose(prog_busy) |-> scl_in && sda_in; endproperty
   a_prog_stop: assert property (p_prog_stop) else $error("program not at stop");
   property p_pwr_up; $rose(rst_n) |-> !charger_on && !watchdog_run; endproperty
   a_pwr_up: assert property (p_pwr_up) else $error("power-up state");
   c_rst: cover property ($fell(reset_out_oe));
   c_prog: cover property ($fell(prog_busy));
   c_chg: cover property ($rose(charger_on));
endmodule // rtcc_slave_chk

bind rtcc_slave rtcc_slave_chk #(.RST_CYCLES(RST_CYCLES)) chk_i (
   .mclk(mclk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
   .on_battery(on_battery), .wd_expire(wd_expire), .sda_oe(sda_oe),
   .reset_out_oe(reset_out_oe), .osc_run(osc_run), .watchdog_run(watchdog_run),
   .watchdog_alarm_flag(watchdog_alarm_flag), .charger_on(charger_on),
   .series_resistor_field(series_resistor_field), .prog_busy(prog_busy)
);

// >>> test_rtc_control_charger_eeprom_page.sv
// Testbench of the control, charger and page slave
`timescale 1ns/1ps
module test_rtc_control_charger_eeprom_page;
   reg mclk = 0, rst_n = 0, on_battery = 0, wd_expire = 0, ack, e;
   wire scl, sda_low, sda_oe, sda_out, rst_oe, osc_run, wd_run, flag, chg_on, chg_d, busy;
   wire [1:0] res;
   wire sda = (sda_low | (sda_oe & !sda_out)) ? 1'b0 : 1'b1; // pull-up
   int fail_count = 0, checks_done = 0, i, j;
   reg [7:0] ex [0:9];
   reg [7:0] d, v;
   initial forever #20 mclk = ~mclk;
   rtcc_slave #(.RST_CYCLES(20), .PROG_CYCLES(400)) uut (.mclk(mclk), .rst_n(rst_n),
      .clk_en(1'b1), .scl_in(scl), .sda_in(sda), .on_battery(on_battery),
      .wd_expire(wd_expire), .sda_oe(sda_oe), .sda_out(sda_out), .reset_out_oe(rst_oe),
      .reset_out(), .osc_run(osc_run), .watchdog_run(wd_run), .watchdog_alarm_flag(flag),
      .charger_on(chg_on), .charger_diode(chg_d), .series_resistor_field(res),
      .prog_busy(busy));
   rtcc_i2c_mst mst (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
   // ==========================================
   // Access tasks
   task chk(input string n, input [7:0] x, input [7:0] g);
      checks_done++;
      if (g !== x) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, x, g);
      end
   endtask
   task settle(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   task ad(input [7:0] a, input x);
      mst.start;
      mst.wbyte(a, ack);
      chk("addr ack", {7'h0, x}, {7'h0, ack});
   endtask
   task wr(input [2:0] b, input [7:0] w, input [7:0] s, input int n);
      ad({4'hd, b, 1'b0}, 1'b1);
      mst.wbyte(w, ack);
      for (i = 0; i < n; i++) mst.wbyte(s + i[7:0], ack);
      chk("data ack", 8'h01, {7'h0, ack});
      mst.stop;
   endtask
   task rd(input [2:0] b, input [7:0] w, input int n);
      ad({4'hd, b, 1'b0}, 1'b1);
      mst.wbyte(w, ack);
      ad({4'hd, b, 1'b1}, 1'b1);
      for (i = 0; i < n; i++) begin
         mst.rbyte(i == n - 1, d);
         chk("read", ex[i], d);
      end
      mst.stop;
   endtask
   task expire;
      @(posedge mclk);
      wd_expire <= 1;
      @(posedge mclk);
      wd_expire <= 0;
      settle(3);
   endtask
   task close_out;
      $display("checks %0d fails %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #2_000_000;
      fail_count++;
      close_out;
   end
   // ==========================================
   // Tests
   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1;
      repeat (4) @(posedge mclk);
      ex[0] = 8'h00;
      rd(0, 8'h0a, 1);
      rd(0, 8'h0c, 1);
      wr(0, 8'h0c, 8'hff, 1);
      ex[0] = 8'h83;
      rd(0, 8'h0c, 1);
      chk("wd run", 8'h01, {7'h0, wd_run});
      chk("osc mains", 8'h01, {7'h0, osc_run});
      on_battery <= 1;
      settle(8);
      chk("osc battery", 8'h00, {7'h0, osc_run});
      wr(0, 8'h0c, 8'h03, 1);
      settle(4);
      chk("osc halt off", 8'h01, {7'h0, osc_run});
      @(posedge mclk);
      on_battery <= 0;
      expire;
      chk("reset pulse", 8'h01, {7'h0, rst_oe});
      settle(30);
      chk("reset end", 8'h00, {7'h0, rst_oe});
      wr(0, 8'h0b, 8'h00, 1);
      wr(0, 8'h0c, 8'h02, 1);
      expire;
      chk("no reset", 8'h00, {7'h0, rst_oe});
      chk("alarm", 8'h01, {7'h0, flag});
      // Bench supply is taken as below the limit for the lowest resistor
      for (j = 0; j < 17; j++) begin
         v = (j == 16) ? 8'h56 : 8'ha0 + j[7:0];
         wr(0, 8'h0a, v, 1);
         ex[0] = v;
         rd(0, 8'h0a, 1);
         settle(2);
         e = v[7:4] == 4'ha && (v[3:2] == 2'h1 || v[3:2] == 2'h2) && v[1:0] != 2'h0;
         chk("charger on", {7'h0, e}, {7'h0, chg_on});
         if (e) begin
            chk("diode", {7'h0, v[3:2] == 2'h2}, {7'h0, chg_d});
            chk("resistor", {6'h0, v[1:0]}, {6'h0, res});
         end
      end
      wr(1, 8'h10, 8'h40, 10);
      ad(8'hd2, 1'b0);
      mst.stop;
      for (j = 0; j < 1000 && busy !== 1'b0; j++) @(negedge mclk);
      chk("prog done", 8'h00, {7'h0, busy});
      for (j = 0; j < 8; j++) ex[j] = 8'h40 + ((j < 2) ? j[7:0] + 8'h08 : j[7:0]);
      rd(1, 8'h10, 8);
      for (j = 0; j < 3; j++) begin
         ad(j == 0 ? 8'hc0 : j == 1 ? 8'hd6 : 8'hd8, 1'b0);
         mst.stop;
      end
      ad(8'hd4, 1'b1);
      mst.stop;
      close_out;
   end
endmodule // test_rtc_control_charger_eeprom_page
